// ---- iab_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Host board model: bus clock, command strobes, DMA acknowledge.
// ****************************************************************
module iab_host (
   input  wire logic               clock,
   input  wire logic               drq,
   input  wire logic               master_oe,
   input  wire logic               iochrdy_oe,
   input  wire logic               io_cs16_oe,
   input  wire logic               mem_cs16_oe,
   input  wire logic               zws_oe,
   input  wire iab_pkg::iab_word_t sd_o,
   input  wire logic [1:0]         sd_oe,
   output var  logic               bclk,
   output var  logic               bale,
   output var  logic               reset_drv,
   output var  logic               aen,
   output var  logic               ior_n,
   output var  logic               iow_n,
   output var  logic               memr_n,
   output var  logic               memw_n,
   output var  logic               sbhe_n,
   output var  logic [19:0]        sa,
   output var  logic [6:0]         la,
   output var  logic               dack_n,
   output var  iab_pkg::iab_word_t sd_i
);
   import iab_pkg::*;
   logic [3:0] div;
   logic       wr_drv;
   logic       aen_f;
   iab_word_t  wr_val;
   int         dcnt, dly, run, rdy_max;
   logic [3:0] seen;
   // Everything starts idle, with strobes and acknowledge high.
   initial begin
      {bclk, bale, reset_drv, aen, sbhe_n, sa, la, sd_i, div, wr_drv, aen_f, wr_val} = '0;
      {ior_n, iow_n, memr_n, memw_n, dack_n} = 5'h1f;
      {dcnt, run, rdy_max, seen} = '0;
      dly = 2;
   end
   // Bus clock of 32 cycles; an undriven data bus toggles every cycle.
   always @(negedge clock) begin
      div <= div + 4'h1;
      if (div == 4'hf) bclk <= ~bclk;
      sd_i <= wr_drv ? wr_val : ~sd_i;
      dcnt <= drq ? dcnt + 1 : 0;
      if (!drq && !dack_n) dly <= 26 - dly;   // Count done: swap the answer delay between 2 and 24.
      dack_n <= !(drq && dcnt >= dly);
      aen <= aen_f || (drq && dcnt >= dly && !master_oe);
   end
   // Note which open-drain lines were pulled while a command was low.
   always @(posedge clock) begin
      run <= iochrdy_oe ? run + 1 : 0;
      if (run > rdy_max) rdy_max <= run;
      if (!(ior_n && iow_n && memr_n && memw_n)) seen <= seen | {zws_oe, mem_cs16_oe,
                                                                io_cs16_oe, iochrdy_oe};
   end
   // One cycle: 0 read port, 1 write port, 2 read memory, 3 write memory.
   task automatic cycle(input logic [1:0] k, input logic [19:0] a, input logic [6:0] l,
                        input logic s, input logic av, input iab_word_t d,
                        output iab_word_t q, output logic [1:0] qe);
      int n;
      seen = 4'h0;
      rdy_max = 0;
      n = 0;
      {sa, la, sbhe_n, aen_f, wr_val, wr_drv, bale} <= {a, l, s, av, d, k[0], 1'b1};
      repeat (8) @(negedge clock);
      {bale, la} <= {1'b0, ~l};
      repeat (32) @(negedge clock);
      {ior_n, iow_n, memr_n, memw_n} <= ~(4'h8 >> k);
      repeat (6) @(negedge clock);
      while (iochrdy_oe && n < 700) begin
         @(negedge clock);
         n++;
      end
      repeat (2) @(negedge clock);
      q = sd_o;
      qe = sd_oe;
      {ior_n, iow_n, memr_n, memw_n, wr_drv, aen_f} <= 6'h3c;
      repeat (8) @(negedge clock);
   endtask : cycle
   // Pulse the bus reset line.
   task automatic bus_reset();
      reset_drv <= 1'b1;
      repeat (6) @(negedge clock);
      reset_drv <= 1'b0;
      repeat (4) @(negedge clock);
   endtask : bus_reset
endmodule : iab_host
`default_nettype wire

// ---- iab_map.svh ----
`ifndef IAB_MAP_SVH
`define IAB_MAP_SVH
// ****************************************************************
// Timing counts and field constants.
// ****************************************************************
`define IAB_CLK_NS   5
`define IAB_MST_NS   15000
`define IAB_MST_CYC  ((`IAB_MST_NS) / (`IAB_CLK_NS))
`define IAB_RDY_NS   2500
`define IAB_RDY_CYC  ((`IAB_RDY_NS) / (`IAB_CLK_NS))
`define IAB_CNT_W    12
`define IAB_IRQ_RTC  8
`define IAB_IRQ_SYS  13
`define IAB_DMA_SYS  4
`define IAB_DMA_16   5
`define IAB_IO_LO    4
`define IAB_IO_HI    9
`define IAB_BE_NONE  2'h0
`define IAB_ZWS_EDGE 2'h2
`endif

// ---- iab_pkg.sv ----
// ****************************************************************
// Types shared by the adapter bus interface.
// ****************************************************************
package iab_pkg;
   typedef enum logic [2:0] {
      iab_st_idle = 3'h0,
      iab_st_dma  = 3'h1,
      iab_st_mreq = 3'h2,
      iab_st_mown = 3'h3
   } iab_st_e;
   typedef logic [15:0] iab_word_t;
   typedef logic [16:0] iab_addr_t;
   // Bus pins as sampled through the synchroniser.
   typedef struct packed {
      logic        bclk;
      logic        bale;
      logic        ior_n;
      logic        iow_n;
      logic        memr_n;
      logic        memw_n;
      logic        aen;
      logic        dack_n;
      logic        sbhe_n;
      logic        rdrv;
      logic [19:0] sa;
      logic [6:0]  la;
      iab_word_t   sd;
   } iab_pins_s;
   // One captured write.
   typedef struct packed {
      iab_addr_t  addr;
      logic       mem;
      logic [1:0] be;
      iab_word_t  data;
   } iab_ent_s;
endpackage : iab_pkg

// ---- iab_top.sv ----
// Functional notes
// [R1] IRQ rises, held high until acknowledged
// [R2] Host ranks IRQ9 highest, IRQ7 lowest
// [R3] Never use interrupt lines 8 or 13
// [R4] Drive read data while IOR active
// [R5] Capture data bus on decoded IOW
// [R6] Host derives SMEMR/SMEMW for low 1Mb
// [R7] Address valid one clock before command
// [R8] Hold DRQ high until DACK asserted
// [R9] Host ranks DMA channel 0 highest
// [R10] Channels 0-3 8-bit, 5-7 16-bit, 4 unused
// [R11] Host acknowledges DMA by DACK low
// [R12] AEN gives DMA controller the bus
// [R13] Host pulses terminal count per channel
// [R14] SBHE and SA0 select byte lanes
// [R15] Master: DACK, MASTER low, wait 1/2 clocks
// [R16] Release MASTER within 15 microseconds
// [R17] MEM CS16 decoded from LA17-LA23 only
// [R18] IO CS16 asserted from IO address decode
// [R19] 0WS from memory decode and command
// [R20] 8-bit 0WS one clock after command
// [R21] Ready low immediately, at most 2.5 us
// [R22] Bus reset high returns logic to idle
// [R23] Latch SA and LA decode at BALE fall
// [R24] Ignore IO matches while AEN active
`timescale 1ns/10ps
`default_nettype none
`include "iab_map.svh"
module iab_top #(
   parameter int         IRQ_LINE = 5,
   parameter int         DMA_CH   = 5,
   parameter logic [9:0] IO_BASE  = 10'h320,
   parameter logic [6:0] MEM_BASE = 7'h06,
   parameter bit         MEM16    = 1'b1
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              bclk,
   input  wire logic              bale,
   input  wire logic              reset_drv,
   input  wire logic              aen,
   input  wire logic              ior_n,
   input  wire logic              iow_n,
   input  wire logic              memr_n,
   input  wire logic              memw_n,
   input  wire logic              sbhe_n,
   input  wire logic [19:0]       sa,
   input  wire logic [6:0]        la,
   input  wire logic              dack_n,
   input  wire iab_pkg::iab_word_t sd_i,
   output var  iab_pkg::iab_word_t sd_o,
   output var  logic [1:0]        sd_oe,
   output var  logic              irq,
   output var  logic              drq,
   output var  logic              iochrdy_o,
   output var  logic              iochrdy_oe,
   output var  logic              io_cs16_n_o,
   output var  logic              io_cs16_oe,
   output var  logic              mem_cs16_n_o,
   output var  logic              mem_cs16_oe,
   output var  logic              zws_n_o,
   output var  logic              zws_oe,
   output var  logic              master_n_o,
   output var  logic              master_oe,
   input  wire logic              irq_set,
   input  wire logic              irq_ack,
   input  wire logic              dma_req,
   output var  logic              dma_gnt,
   input  wire logic              mst_req,
   output var  logic              mst_addr_en,
   output var  logic              mst_cmd_en,
   output var  logic              rd_req,
   output var  iab_pkg::iab_addr_t rd_addr,
   output var  logic              rd_mem,
   output var  logic [1:0]        rd_be,
   input  wire logic              rd_ack,
   input  wire iab_pkg::iab_word_t rd_data,
   output var  logic              wr_valid,
   input  wire logic              wr_ready,
   output var  iab_pkg::iab_addr_t wr_addr,
   output var  logic              wr_mem,
   output var  logic [1:0]        wr_be,
   output var  iab_pkg::iab_word_t wr_data
);
   import iab_pkg::*;

   // ****************************************************************
   // Parameter checks.
   // ****************************************************************
   if (IRQ_LINE == `IAB_IRQ_RTC || IRQ_LINE == `IAB_IRQ_SYS ||
       IRQ_LINE < 3 || IRQ_LINE > 15) begin : g_bad_irq // [R3]
      $error("Interrupt line not offered on the channel.");
   end
   if (DMA_CH == `IAB_DMA_SYS || DMA_CH < 0 || DMA_CH > 7) begin : g_bad_dma // [R10]
      $error("DMA channel not offered on the channel.");
   end
   if (`IAB_MST_CYC >= (1 << `IAB_CNT_W)) begin : g_bad_cnt
      $error("Counter too narrow for master limit.");
   end

   // ****************************************************************
   // Synchroniser for all bus pins.
   // ****************************************************************
   iab_pins_s pin_w;
   iab_pins_s m_q;
   iab_pins_s s_q;
   logic      clr;

   assign pin_w = {bclk, bale, ior_n, iow_n, memr_n, memw_n, aen, dack_n,
                   sbhe_n, reset_drv, sa, la, sd_i};

   // Two flops before any logic looks at a pin.
   always_ff @(posedge clock) begin
      m_q <= pin_w;
      s_q <= m_q;
   end

   // Bus reset acts like the local reset.
   assign clr = !rst_n || s_q.rdrv; // [R22]

   // ****************************************************************
   // Core state.
   // ****************************************************************
   iab_st_e                st_q, st_d;
   logic [`IAB_CNT_W-1:0]  mcnt_q, mcnt_d, rcnt_q, rcnt_d;
   logic [1:0]             bc_q, bc_d, zc_q, zc_d, pv_q, pv_d, rbe_q, rbe_d;
   logic [19:0]            a_q, a_d;
   logic                   lam_q, lam_d, sbh_q, sbh_d;
   logic                   act_q, act_d, wrk_q, wrk_d, rdw_q, rdw_d;
   logic                   irq_q, irq_d, drq_q, drq_d, gnt_q, gnt_d;
   logic                   mo_q, mo_d, ae_q, ae_d, ce_q, ce_d;
   logic                   rdy_q, rdy_d, iocs_q, iocs_d;
   logic                   mcs_q, mcs_d, zws_q, zws_d;
   logic                   rq_q, rq_d;
   iab_word_t              sdo_q, sdo_d;
   logic [1:0]             sdoe_q, sdoe_d;
   iab_ent_s               wc_q, wc_d;
   logic                   io_hit, rd_c, wr_c, mem_c, brise, bfall;
   logic                   push, wend;
   logic [1:0]             be_w;
   // Two-entry buffer: head drives the user port, spare absorbs a stall.
   iab_ent_s               hd_q, hd_d, sp_q, sp_d;
   logic                   hv_q, hv_d, sv_q, sv_d;

   // Next state of the whole bus engine.
   always_comb begin
      st_d   = st_q;
      mcnt_d = mcnt_q;
      bc_d   = bc_q;
      pv_d   = {s_q.bclk, s_q.bale};
      brise  = s_q.bclk && !pv_q[1];
      bfall  = !s_q.bclk && pv_q[1];
      // Address follows the pins while BALE is high, frozen on its fall.
      a_d    = s_q.bale ? s_q.sa : a_q; // [R23]
      lam_d  = s_q.bale ? (s_q.la == MEM_BASE) : lam_q; // [R23]
      sbh_d  = s_q.bale ? s_q.sbhe_n : sbh_q;
      be_w   = {!sbh_q, !a_q[0]}; // [R14]
      rbe_d  = be_w; // [R14]
      io_hit = (a_q[`IAB_IO_HI:`IAB_IO_LO] == IO_BASE[`IAB_IO_HI:`IAB_IO_LO])
               && !s_q.aen; // [R24]
      rd_c   = (io_hit && !s_q.ior_n) || (lam_q && !s_q.memr_n);
      wr_c   = (io_hit && !s_q.iow_n) || (lam_q && !s_q.memw_n);
      mem_c  = lam_q && !(s_q.memr_n && s_q.memw_n);
      act_d  = rd_c || wr_c;
      wrk_d  = wr_c;
      wend   = wrk_q && !wr_c;
      push   = wend && !sv_q && (wc_q.be != `IAB_BE_NONE); // [R5] [R14]
      irq_d  = irq_set || (irq_q && !irq_ack); // [R1]
      drq_d  = drq_q;
      gnt_d  = 1'b0;
      mo_d   = mo_q;
      ae_d   = ae_q;
      ce_d   = ce_q;
      rq_d   = 1'b0;
      rdw_d  = rdw_q;
      sdo_d  = sdo_q;
      sdoe_d = sdoe_q;
      wc_d   = wc_q;
      // Keep the latest bus value while the write strobe is low.
      if (wr_c) begin
         wc_d = '{addr: a_q[16:0], mem: mem_c, be: be_w, data: s_q.sd}; // [R5]
      end
      // Read: ask the user side, then drive lanes until the strobe ends.
      if (rd_c && !act_q) begin
         rq_d  = 1'b1;
         rdw_d = 1'b1;
      end else if (rdw_q && rd_c && rd_ack) begin
         rdw_d  = 1'b0;
         sdo_d  = rd_data;
         sdoe_d = be_w; // [R4] [R14]
      end
      if (!rd_c) begin
         rdw_d  = 1'b0;
         sdoe_d = 2'h0;
      end
      // Stretch while data is missing or the buffer is full.
      rdy_d  = ((rd_c && (rdw_q || !act_q)) || (wr_c && sv_q)) &&
               (rcnt_q < `IAB_CNT_W'(`IAB_RDY_CYC)); // [R21]
      rcnt_d = act_d ? (rdy_d ? rcnt_q + 1'b1 : rcnt_q) : '0; // [R21]
      iocs_d = io_hit; // [R18]
      mcs_d  = s_q.bale ? (s_q.la == MEM_BASE) : lam_q; // [R17]
      // Falling clock edges seen with the command active.
      zc_d   = mem_c ? ((bfall && zc_q != `IAB_ZWS_EDGE) ? zc_q + 1'b1 : zc_q)
                     : 2'h0; // [R20]
      zws_d  = mem_c && !rdy_d &&
               (MEM16 || zc_q == `IAB_ZWS_EDGE); // [R19] [R20]
      // DMA request and cascade bus master sequencing.
      case (st_q)
         iab_st_idle: begin
            mcnt_d = '0;
            bc_d   = 2'h0;
            if (mst_req) begin
               st_d  = iab_st_mreq;
               drq_d = 1'b1;
            end else if (dma_req) begin
               st_d  = iab_st_dma;
               drq_d = 1'b1; // [R8]
            end
         end
         iab_st_dma: begin
            if (!s_q.dack_n) begin // [R8]
               drq_d = 1'b0;
               gnt_d = 1'b1;
               st_d  = iab_st_idle;
            end
         end
         iab_st_mreq: begin
            if (!s_q.dack_n) begin // [R15]
               mo_d   = 1'b1;
               mcnt_d = '0;
               bc_d   = 2'h0;
               st_d   = iab_st_mown;
            end
         end
         iab_st_mown: begin
            mcnt_d = mcnt_q + 1'b1;
            if (brise && bc_q != 2'h3) begin
               bc_d = bc_q + 1'b1;
            end
            ae_d = (bc_d >= 2'h2); // [R15]
            ce_d = (bc_d == 2'h3); // [R15] [R7]
            if (!mst_req || s_q.dack_n ||
                mcnt_q == `IAB_CNT_W'(`IAB_MST_CYC - 1)) begin // [R16]
               mo_d  = 1'b0;
               ae_d  = 1'b0;
               ce_d  = 1'b0;
               drq_d = 1'b0;
               st_d  = iab_st_idle;
            end
         end
         default: begin
            st_d  = iab_st_idle;
            drq_d = 1'b0;
            mo_d  = 1'b0;
         end
      endcase
   end

   // Registers of the bus engine.
   always_ff @(posedge clock) begin
      if (clr) begin // [R22]
         st_q   <= iab_st_idle;
         mcnt_q <= '0;
         rcnt_q <= '0;
         bc_q   <= 2'h0;
         zc_q   <= 2'h0;
         pv_q   <= 2'h0;
         a_q    <= 20'h00000;
         lam_q  <= 1'b0;
         sbh_q  <= 1'b1;
         act_q  <= 1'b0;
         wrk_q  <= 1'b0;
         rdw_q  <= 1'b0;
         irq_q  <= 1'b0;
         drq_q  <= 1'b0;
         gnt_q  <= 1'b0;
         mo_q   <= 1'b0;
         ae_q   <= 1'b0;
         ce_q   <= 1'b0;
         rdy_q  <= 1'b0;
         iocs_q <= 1'b0;
         mcs_q  <= 1'b0;
         zws_q  <= 1'b0;
         rq_q   <= 1'b0;
         sdo_q  <= 16'h0000;
         sdoe_q <= 2'h0;
         rbe_q  <= 2'h0;
         wc_q   <= '0;
      end else begin
         st_q   <= st_d;
         mcnt_q <= mcnt_d;
         rcnt_q <= rcnt_d;
         bc_q   <= bc_d;
         zc_q   <= zc_d;
         pv_q   <= pv_d;
         a_q    <= a_d;
         lam_q  <= lam_d;
         sbh_q  <= sbh_d;
         act_q  <= act_d;
         wrk_q  <= wrk_d;
         rdw_q  <= rdw_d;
         irq_q  <= irq_d;
         drq_q  <= drq_d;
         gnt_q  <= gnt_d;
         mo_q   <= mo_d;
         ae_q   <= ae_d;
         ce_q   <= ce_d;
         rdy_q  <= rdy_d;
         iocs_q <= iocs_d;
         mcs_q  <= mcs_d;
         zws_q  <= zws_d;
         rq_q   <= rq_d;
         sdo_q  <= sdo_d;
         sdoe_q <= sdoe_d;
         rbe_q  <= rbe_d;
         wc_q   <= wc_d;
      end
   end

   // ****************************************************************
   // Write buffer.
   // ****************************************************************
   // Pop the head, promote the spare, then place a new word.
   always_comb begin
      hd_d = hd_q;
      sp_d = sp_q;
      hv_d = hv_q;
      sv_d = sv_q;
      if (hv_q && wr_ready) begin
         hv_d = sv_q;
         hd_d = sp_q;
         sv_d = 1'b0;
      end
      if (push) begin
         if (!hv_d) begin
            hd_d = wc_q;
            hv_d = 1'b1;
         end else begin
            sp_d = wc_q;
            sv_d = 1'b1;
         end
      end
   end

   // Buffer registers.
   always_ff @(posedge clock) begin
      if (clr) begin
         hd_q <= '0;
         sp_q <= '0;
         hv_q <= 1'b0;
         sv_q <= 1'b0;
      end else begin
         hd_q <= hd_d;
         sp_q <= sp_d;
         hv_q <= hv_d;
         sv_q <= sv_d;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   assign sd_o         = sdo_q;
   assign sd_oe        = sdoe_q;
   assign irq          = irq_q;
   assign drq          = drq_q;
   assign dma_gnt      = gnt_q;
   assign mst_addr_en  = ae_q;
   assign mst_cmd_en   = ce_q;
   assign master_oe    = mo_q;
   assign iochrdy_oe   = rdy_q;
   assign io_cs16_oe   = iocs_q;
   assign mem_cs16_oe  = mcs_q;
   assign zws_oe       = zws_q;
   // Open-drain pins only ever pull low, so their data is a fixed zero
   // and the enable flop alone says whether the pin is pulled.
   assign iochrdy_o    = 1'b0;
   assign io_cs16_n_o  = 1'b0;
   assign mem_cs16_n_o = 1'b0;
   assign zws_n_o      = 1'b0;
   assign master_n_o   = 1'b0;
   assign rd_req       = rq_q;
   assign rd_addr      = a_q[16:0];
   assign rd_mem       = lam_q;
   assign rd_be        = rbe_q;
   assign wr_valid     = hv_q;
   assign wr_addr      = hd_q.addr;
   assign wr_mem       = hd_q.mem;
   assign wr_be        = hd_q.be;
   assign wr_data      = hd_q.data;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   logic [`IAB_CNT_W-1:0] hm_q, hr_q;

   // Cycles that MASTER and the ready stretch have been held.
   always_ff @(posedge clock) begin
      hm_q <= (clr || !mo_q) ? '0 : hm_q + 1'b1;
      hr_q <= (clr || !rdy_q) ? '0 : hr_q + 1'b1;
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (clr);

   irq_hold_a : assert property (irq_q && !irq_ack |=> irq_q) // [R1]
      else $error("Interrupt dropped before acknowledge.");
   drq_hold_a : assert property (st_q == iab_st_dma && s_q.dack_n |=> drq_q) // [R8]
      else $error("DMA request dropped before acknowledge.");
   cmd_wait_a : assert property ($rose(mo_q) |-> !ce_q [*3]) // [R15]
      else $error("Command enabled too early after MASTER.");
   addr_first_a : assert property ($rose(ce_q) |-> $past(ae_q)) // [R7]
      else $error("Command enabled without address held.");
   master_limit_a : assert property (hm_q <= `IAB_CNT_W'(`IAB_MST_CYC)) // [R16]
      else $error("MASTER held beyond limit.");
   ready_limit_a : assert property (hr_q <= `IAB_CNT_W'(`IAB_RDY_CYC)) // [R21]
      else $error("Ready stretched beyond limit.");
   aen_ignore_a : assert property (s_q.aen |=> !iocs_q) // [R24]
      else $error("IO decode active during AEN.");
   read_drive_a : assert property (|sdoe_q |-> $past(rd_c)) // [R4]
      else $error("Data driven without a read strobe.");
   zws_cmd_a : assert property (zws_q |-> $past(mem_c) && !rdy_q) // [R19]
      else $error("Zero wait asserted without a command.");
   lane_rsv_a : assert property (hv_q |-> hd_q.be != `IAB_BE_NONE) // [R14]
      else $error("Reserved lane code accepted.");
   write_take_a : assert property (push && !hv_q |=> hv_q) // [R5]
      else $error("Write word not taken.");
endmodule : iab_top
`default_nettype wire

// ---- test_iab_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Self-checking bench of the adapter bus interface.
// ****************************************************************
module test_iab_top;
   import iab_pkg::*;
   logic       clock, rst_n, bclk, bale, reset_drv, aen, ior_n, iow_n, memr_n, memw_n;
   logic       sbhe_n, dack_n, irq, drq, iochrdy_oe, io_cs16_oe, mem_cs16_oe, zws_oe;
   logic       master_oe, irq_set, irq_ack, dma_req, dma_gnt, mst_req, mst_addr_en;
   logic       mst_cmd_en, rd_req, rd_mem, rd_ack, wr_valid, wr_mem, stall;
   logic       wr_ready = 1'b0;
   logic [19:0] sa;
   logic [6:0] la;
   logic [1:0] sd_oe, rd_be, wr_be;
   iab_word_t  sd_i, sd_o, rd_data, wr_data, last_rd;
   iab_addr_t  rd_addr, wr_addr;
   iab_ent_s   we, re, wq[$], rq[$];
   int         n, ta, tc, rr, cyc, n_mismatch, checks_done;
   int         seed = 32'h147a;
   iab_top #(.IRQ_LINE(5), .DMA_CH(5), .MEM_BASE(7'h06)) dut (
      .clock, .rst_n, .bclk, .bale, .reset_drv, .aen, .ior_n, .iow_n, .memr_n, .memw_n,
      .sbhe_n, .sa, .la, .dack_n, .sd_i, .sd_o, .sd_oe, .irq, .drq, .iochrdy_o(),
      .iochrdy_oe, .io_cs16_n_o(), .io_cs16_oe, .mem_cs16_n_o(), .mem_cs16_oe, .zws_n_o(),
      .zws_oe, .master_n_o(), .master_oe, .irq_set, .irq_ack, .dma_req, .dma_gnt, .mst_req,
      .mst_addr_en, .mst_cmd_en, .rd_req, .rd_addr, .rd_mem, .rd_be, .rd_ack, .rd_data,
      .wr_valid, .wr_ready, .wr_addr, .wr_mem, .wr_be, .wr_data);
   iab_host host (.clock, .drq, .master_oe, .iochrdy_oe, .io_cs16_oe, .mem_cs16_oe, .zws_oe,
      .sd_o, .sd_oe, .bclk, .bale, .reset_drv, .aen, .ior_n, .iow_n, .memr_n, .memw_n,
      .sbhe_n, .sa, .la, .dack_n, .sd_i);
   // Compare one value and count the result.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Print the counts and the verdict, then stop.
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   function automatic iab_word_t mask(input logic [1:0] b);
      return {{8{b[1]}}, {8{b[0]}}};
   endfunction : mask
   // One bus cycle; code is {byte high enable, address bit 0}.
   task automatic xfer(input logic [1:0] k, input logic [1:0] c, input logic av,
                       input logic miss, input logic keep);
      int          rv;
      logic        hit;
      logic [19:0] a;
      iab_ent_s    e;
      iab_word_t   q;
      logic [1:0]  qe;
      rv = $random(seed);
      hit = !av && !miss;
      a = k[1] ? {3'h6, rv[16:10], 1'b0, rv[8:1], c[0]} : {10'h0, 5'h19, miss, rv[3:1], c[0]};
      e = '{a[16:0], k[1], ~c, rv[31:16]};
      if (hit && !k[0]) rq.push_back(e);
      if (hit && k[0] && keep && c != 2'h3) wq.push_back(e);
      host.cycle(k, a, (k[1] && !miss) ? 7'h06 : 7'h05, c[1], av, e.data, q, qe);
      if (hit && !k[0]) begin
         chk("sd_oe", e.be, qe);
         chk("sd_o", last_rd & mask(e.be), q & mask(e.be));
      end
      chk("io_cs16", !k[1] && hit, host.seen[1]);
      chk("mem_cs16", k[1] && hit, host.seen[2]);
      chk("zws", k[1] && hit, host.seen[3]);
      chk("iochrdy", hit && !(k[0] && keep), host.seen[0]);
   endtask : xfer
   // The clock.
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Cut a hung run short.
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   // Receiver side of the buffer: stalls at random or on demand.
   always @(negedge clock) begin
      rr = $random(seed);
      wr_ready <= !stall && rr[0];
   end
   // Match each word leaving the buffer against the oldest note.
   always @(posedge clock) begin
      if (rst_n === 1'b1 && wr_valid === 1'b1 && wr_ready === 1'b1) begin
         we = (wq.size() > 0) ? wq.pop_front() : '0;
         chk("wr_addr", we.addr, wr_addr);
         chk("wr_mem", we.mem, wr_mem);
         chk("wr_be", we.be, wr_be);
         chk("wr_data", we.data & mask(we.be), wr_data & mask(we.be));
      end
   end
   // Answer each read request after a random delay with random data.
   initial begin
      int r;
      forever begin
         @(posedge clock);
         if (rst_n === 1'b1 && rd_req === 1'b1) begin
            re = (rq.size() > 0) ? rq.pop_front() : '0;
            chk("rd_addr", re.addr, rd_addr);
            chk("rd_mem", re.mem, rd_mem);
            chk("rd_be", re.be, rd_be);
            r = $random(seed);
            repeat (int'(r[2:0]) + 1) @(negedge clock);
            last_rd = r[31:16];
            {rd_data, rd_ack} <= {r[31:16], 1'b1};
            @(negedge clock);
            rd_ack <= 1'b0;
         end
      end
   end
   // Main sequence.
   initial begin
      {rst_n, irq_set, irq_ack, dma_req, mst_req, rd_ack, rd_data, stall} = '0;
      repeat (4) @(negedge clock);
      rst_n <= 1'b1;
      repeat (4) @(negedge clock);
      chk("idle", 0, {irq, drq, wr_valid, sd_oe, master_oe, iochrdy_oe});
      $display("test reset done");
      irq_set <= 1'b1;
      @(negedge clock);
      irq_set <= 1'b0;
      repeat (20) @(negedge clock);
      chk("irq", 1, irq);
      {irq_set, irq_ack} <= 2'h3;
      @(negedge clock);
      chk("irq", 1, irq);
      irq_set <= 1'b0;
      @(negedge clock);
      chk("irq", 0, irq);
      irq_ack <= 1'b0;
      $display("test interrupt done");
      for (int i = 0; i < 12; i++) xfer(i[1:0], i[3:2], 1'b0, 1'b0, 1'b1);
      xfer(2'h1, 2'h3, 1'b0, 1'b0, 1'b1);
      xfer(2'h3, 2'h3, 1'b0, 1'b0, 1'b1);
      xfer(2'h1, 2'h0, 1'b1, 1'b0, 1'b1);
      xfer(2'h0, 2'h0, 1'b1, 1'b0, 1'b1);
      xfer(2'h1, 2'h0, 1'b0, 1'b1, 1'b1);
      xfer(2'h2, 2'h0, 1'b0, 1'b1, 1'b1);
      repeat (20) @(negedge clock);
      $display("test cycles done");
      stall = 1'b1;
      for (int i = 0; i < 3; i++) xfer(2'h1, 2'h0, 1'b0, 1'b0, i < 2);
      chk("ready_max", 1, host.rdy_max <= 500 && host.rdy_max >= 450);
      chk("wr_valid", 1, wr_valid);
      stall = 1'b0;
      repeat (40) @(negedge clock);
      chk("drained", 0, {wq.size() != 0, wr_valid});
      $display("test buffer done");
      for (int i = 0; i < 2; i++) begin
         dma_req <= 1'b1;
         @(negedge clock);
         dma_req <= 1'b0;
         repeat (2) @(negedge clock);
         n = 0;
         while (dack_n === 1'b1 && n < 100) begin
            chk("drq", 1, drq);
            @(negedge clock);
            n++;
         end
         n = 0;
         while (dma_gnt !== 1'b1 && n < 10) begin
            @(negedge clock);
            n++;
         end
         chk("dma_gnt", 1, dma_gnt);
         repeat (2) @(negedge clock);
         chk("drq", 0, drq);
         repeat (30) @(negedge clock);
      end
      $display("test dma done");
      mst_req <= 1'b1;
      n = 0;
      while (master_oe !== 1'b1 && n < 100) begin
         @(negedge clock);
         n++;
      end
      chk("mst_start", 0, {dack_n, mst_addr_en, mst_cmd_en});
      {n, ta, tc} = '0;
      while (master_oe === 1'b1 && n < 3100) begin
         if (mst_addr_en === 1'b1 && ta == 0) ta = n;
         if (mst_cmd_en === 1'b1 && tc == 0) tc = n;
         @(negedge clock);
         n++;
      end
      mst_req <= 1'b0;
      chk("mst_order", 1, ta >= 32 && tc - ta >= 32);
      chk("mst_tenure", 1, n <= 3000 && n > 2900);
      repeat (100) @(negedge clock);
      $display("test master done");
      irq_set <= 1'b1;
      @(negedge clock);
      irq_set <= 1'b0;
      host.bus_reset();
      chk("irq", 0, {irq, drq, master_oe});
      $display("test bus reset done");
      wrap_up();
   end
endmodule : test_iab_top
`default_nettype wire
